// >>> core/lcv_pkg.sv
/*
  Shared constants and types for the two-channel light conversion block:
  oscillator and integration timing, counter limits, serial slave
  addresses, register indices and the packed state records.
  Assumes a 50 MHz system clock.
*/
package lcv_pkg;

  localparam int CLK_HZ        = 50_000_000;
  localparam int OSC_HZ        = 735_000;
  localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int INTEG_UNIT    = 918;
  localparam int MULT_00       = 11;
  localparam int MULT_01       = 81;
  localparam int MULT_10       = 322;
  localparam int CNT_OFFSET    = 2;
  localparam int LOW_GAIN_DIV  = 16;
  localparam logic [16:0] CNT_CAP = 17'h10001;

  localparam int TOUT_MIN_MS   = 25;
  localparam int TOUT_MAX_MS   = 35;
  localparam int TOUT_CYC      = (CLK_HZ / 1000) * TOUT_MIN_MS;

  localparam logic [6:0] ADDR_GND   = 7'h29;
  localparam logic [6:0] ADDR_FLOAT = 7'h39;
  localparam logic [6:0] ADDR_VDD   = 7'h49;
  localparam logic [6:0] ADDR_ALERT = 7'h0c;

  localparam logic [1:0] STRAP_GND   = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_VDD   = 2'h2;

  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_ID     = 4'ha;
  localparam logic [3:0] REG_BB_LO  = 4'hc;
  localparam logic [3:0] REG_BB_HI  = 4'hd;
  localparam logic [3:0] REG_IR_LO  = 4'he;
  localparam logic [3:0] REG_IR_HI  = 4'hf;

  localparam int          CMD_BIT     = 7;
  localparam int          TIM_GAIN    = 4;
  localparam logic [7:0]  TIMING_RST  = 8'h02;
  localparam logic [7:0]  ID_VALUE    = 8'h5a;  // Arbitrary value.

  typedef enum logic [6:0] {
    LCV_IDLE  = 7'h01,
    LCV_ADDR  = 7'h02,
    LCV_ACK_A = 7'h04,
    LCV_WR    = 7'h08,
    LCV_ACK_W = 7'h10,
    LCV_RD    = 7'h20,
    LCV_ACK_R = 7'h40
  } lcv_bus_st_t;

  typedef struct packed {
    logic [16:0] cnt;
    logic        pend;
    logic        phase;
    logic [3:0]  pre;
    logic [15:0] res;
    logic        vld;
  } lcv_chan_t;

  typedef struct packed {
    logic        scl_m, scl_s, scl_p;
    logic        sda_m, sda_s, sda_p;
    logic        bbp_m, bbp_s, irp_m, irp_s;
    logic [1:0]  sel_m, sel_s;
    logic [1:0]  strap_wait;
    logic        strap_ok;
    logic [6:0]  own_addr;
    logic [7:0]  osc_cnt;
    logic [15:0] unit_cnt;
    logic [8:0]  mult_cnt;
    logic [7:0]  timing;
    logic [7:0]  cur_tim;
    logic [15:0] bb_res, ir_res;
    logic [7:0]  bb_hi, ir_hi;
    lcv_bus_st_t st;
    logic [3:0]  bit_cnt;
    logic [7:0]  sh, tx;
    logic        rw, nack;
    logic [3:0]  ptr;
    logic [23:0] tout_cnt;
    logic        sda_out, sda_oe_n;
  } lcv_top_st_t;

endpackage : lcv_pkg

// >>> core/lcv_chan.sv
/*
  One integrating channel counter: takes light pulses, counts at most one
  per two oscillator periods, removes the fixed offset and saturates.
  Assumes pulses, oscillator tick and end-of-integration on clk_sys.
*/
`timescale 1ns/1ps
module lcv_chan
  import lcv_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        osc_tick,
  input  wire logic        light_pulse,
  input  wire logic        low_gain,
  input  wire logic        integ_done,
  output logic [15:0]      result,
  output logic             result_vld
);

  lcv_chan_t q_ff, nxt_q;

  always_comb begin
    nxt_q     = q_ff;
    nxt_q.vld = 1'b0;
    if (light_pulse) begin
      if (!low_gain) begin
        nxt_q.pend = 1'b1;
      end else if (q_ff.pre == 4'(LOW_GAIN_DIV - 1)) begin
        nxt_q.pre  = 4'h0;
        nxt_q.pend = 1'b1;
      end else begin
        nxt_q.pre = q_ff.pre + 4'h1;
      end
    end
    if (osc_tick) begin
      nxt_q.phase = ~q_ff.phase;
      // Only every second oscillator period may add a count.
      if (q_ff.phase && q_ff.pend) begin
        nxt_q.pend = 1'b0;
        if (q_ff.cnt != CNT_CAP) begin
          nxt_q.cnt = q_ff.cnt + 17'h1;
        end
      end
    end
    if (integ_done) begin
      // The closing oscillator tick may still add a count, so the result is
      // taken from the updated count; otherwise full scale falls one short.
      nxt_q.vld   = 1'b1;
      nxt_q.res   = (nxt_q.cnt > 17'(CNT_OFFSET)) ?
                    16'(nxt_q.cnt - 17'(CNT_OFFSET)) : 16'h0;
      nxt_q.cnt   = 17'h0;
      nxt_q.pend  = 1'b0;
      nxt_q.phase = 1'b0;
      nxt_q.pre   = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign result     = q_ff.res;
  assign result_vld = q_ff.vld;

endmodule : lcv_chan

// >>> core/lcv_top.sv
/*
  Two-channel light conversion sequencer with its two-wire serial slave.
  Assumes scl, sda, strap and light pulses arrive asynchronously; sda is
  open drain, driven low only, and the board pulls the wire up.
*/
//
// Contract
// - An integration lasts 11, 81 or 322 times 918 oscillator periods by timing code.
// - A channel counts at most once per two oscillator periods and loses a two-count offset.
// - Each result saturates at 65535.
// - Low gain gives one sixteenth of the high-gain conversion gain.
// - Both channels integrate over exactly the same interval.
// - Each result register is loaded only when the integration has completed.
// - Results are double buffered so a read never sees a half-updated value.
// - A new integration starts by itself right after the result transfer.
// - The slave address is 0101001, 0111001 or 1001001 for strap ground, float or supply.
// - The alert response address 0001100 is also recognised.
// - A clock or data line held low for 25 to 35 ms resets the interface.
// - A received byte with its top bit set is a pointer byte, not data.
// - The low four bits of the pointer byte select the register.
// - Every read byte returns the register selected by the stored pointer.
// - The broadband result sits low byte at Ch and high byte at Dh.
`timescale 1ns/1ps
module lcv_top
  import lcv_pkg::*;
#(
  parameter int OSC_DIV_P    = OSC_DIV,
  parameter int INTEG_UNIT_P = INTEG_UNIT,
  parameter int TOUT_CYC_P   = TOUT_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [1:0]  addr_sel,
  input  wire logic        bb_pulse,
  input  wire logic        ir_pulse,
  output logic             sda_out,
  output logic             sda_oe_n
);

  if (OSC_DIV_P < 2 || OSC_DIV_P > 256) begin : g_bad_div
    $error("OSC_DIV_P must lie in 2..256");
  end
  if (INTEG_UNIT_P < 1 || INTEG_UNIT_P > 65536) begin : g_bad_unit
    $error("INTEG_UNIT_P must lie in 1..65536");
  end
  if (TOUT_CYC_P < 2 || TOUT_CYC_P > 16777215) begin : g_bad_tout
    $error("TOUT_CYC_P must lie in 2..16777215");
  end

  lcv_top_st_t q_ff, nxt_q;
  logic        osc_tick, integ_done, unit_last;
  logic [8:0]  cur_mult;
  logic [15:0] bb_val, ir_val;
  logic        bb_vld, ir_vld;
  logic        scl_rise, scl_fall, bus_start, bus_stop, addr_hit;

  always_comb begin
    unique case (q_ff.cur_tim[1:0])
      2'h0:    cur_mult = 9'(MULT_00);
      2'h1:    cur_mult = 9'(MULT_01);
      default: cur_mult = 9'(MULT_10);
    endcase
  end

  assign osc_tick   = (q_ff.osc_cnt == 8'(OSC_DIV_P - 1));
  assign unit_last  = (q_ff.unit_cnt == 16'(INTEG_UNIT_P - 1));
  assign integ_done = osc_tick && unit_last && (q_ff.mult_cnt == cur_mult - 9'h1);

  // One end-of-integration strobe closes both channels together.
  lcv_chan u_bb (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .osc_tick    (osc_tick),
    .light_pulse (q_ff.bbp_s),
    .low_gain    (q_ff.cur_tim[TIM_GAIN]),
    .integ_done  (integ_done),
    .result      (bb_val),
    .result_vld  (bb_vld)
  );

  lcv_chan u_ir (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .osc_tick    (osc_tick),
    .light_pulse (q_ff.irp_s),
    .low_gain    (q_ff.cur_tim[TIM_GAIN]),
    .integ_done  (integ_done),
    .result      (ir_val),
    .result_vld  (ir_vld)
  );

  assign scl_rise  = q_ff.scl_s && !q_ff.scl_p;
  assign scl_fall  = !q_ff.scl_s && q_ff.scl_p;
  assign bus_start = q_ff.scl_s && q_ff.scl_p && q_ff.sda_p && !q_ff.sda_s;
  assign bus_stop  = q_ff.scl_s && q_ff.scl_p && !q_ff.sda_p && q_ff.sda_s;
  assign addr_hit  = (q_ff.sh[7:1] == q_ff.own_addr) ||
                     (q_ff.sh[7:1] == ADDR_ALERT);

  // The high byte is served from a copy taken when the low byte is read,
  // so a result update between the two bytes cannot tear the pair.
  function automatic logic [7:0] reg_byte(input lcv_top_st_t s);
    logic [7:0] b;
    b = 8'h0;
    unique case (s.ptr)
      REG_TIMING: b = s.timing;
      REG_ID:     b = ID_VALUE;
      REG_BB_LO:  b = s.bb_res[7:0];
      REG_BB_HI:  b = s.bb_hi;
      REG_IR_LO:  b = s.ir_res[7:0];
      REG_IR_HI:  b = s.ir_hi;
      default:    b = 8'h0;
    endcase
    return b;
  endfunction : reg_byte

  always_comb begin
    nxt_q         = q_ff;
    nxt_q.scl_m   = scl_in;
    nxt_q.scl_s   = q_ff.scl_m;
    nxt_q.scl_p   = q_ff.scl_s;
    nxt_q.sda_m   = sda_in;
    nxt_q.sda_s   = q_ff.sda_m;
    nxt_q.sda_p   = q_ff.sda_s;
    nxt_q.bbp_m   = bb_pulse;
    nxt_q.bbp_s   = q_ff.bbp_m;
    nxt_q.irp_m   = ir_pulse;
    nxt_q.irp_s   = q_ff.irp_m;
    nxt_q.sel_m   = addr_sel;
    nxt_q.sel_s   = q_ff.sel_m;
    nxt_q.sda_out = 1'b0;

    // The strap is caught once, after it has settled through the synchroniser.
    if (!q_ff.strap_ok) begin
      if (q_ff.strap_wait == 2'h3) begin
        nxt_q.strap_ok = 1'b1;
        unique case (q_ff.sel_s)
          STRAP_GND:   nxt_q.own_addr = ADDR_GND;
          STRAP_FLOAT: nxt_q.own_addr = ADDR_FLOAT;
          default:     nxt_q.own_addr = ADDR_VDD;
        endcase
      end else begin
        nxt_q.strap_wait = q_ff.strap_wait + 2'h1;
      end
    end

    nxt_q.osc_cnt = osc_tick ? 8'h0 : q_ff.osc_cnt + 8'h1;
    if (osc_tick) begin
      nxt_q.unit_cnt = unit_last ? 16'h0 : q_ff.unit_cnt + 16'h1;
      if (unit_last) begin
        nxt_q.mult_cnt = q_ff.mult_cnt + 9'h1;
      end
    end
    if (integ_done) begin
      nxt_q.mult_cnt = 9'h0;
      nxt_q.cur_tim  = q_ff.timing;
    end

    if (bb_vld) begin
      nxt_q.bb_res = bb_val;
    end
    if (ir_vld) begin
      nxt_q.ir_res = ir_val;
    end

    if (!q_ff.scl_s || !q_ff.sda_s) begin
      if (q_ff.tout_cnt != 24'(TOUT_CYC_P - 1)) begin
        nxt_q.tout_cnt = q_ff.tout_cnt + 24'h1;
      end
    end else begin
      nxt_q.tout_cnt = 24'h0;
    end

    unique case (q_ff.st)
      LCV_IDLE: begin
        nxt_q.sda_oe_n = 1'b1;
      end
      LCV_ADDR: begin
        if (scl_rise) begin
          nxt_q.sh      = {q_ff.sh[6:0], q_ff.sda_s};
          nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
        end else if (scl_fall && q_ff.bit_cnt == 4'h8) begin
          nxt_q.bit_cnt = 4'h0;
          nxt_q.rw      = q_ff.sh[0];
          if (addr_hit) begin
            nxt_q.st       = LCV_ACK_A;
            nxt_q.sda_oe_n = 1'b0;
          end else begin
            nxt_q.st = LCV_IDLE;
          end
        end
      end
      LCV_ACK_A, LCV_ACK_R: begin
        if (scl_rise) begin
          nxt_q.nack = q_ff.sda_s;
        end
        if (scl_fall) begin
          nxt_q.bit_cnt = 4'h0;
          if (q_ff.st == LCV_ACK_R && q_ff.nack) begin
            nxt_q.st       = LCV_IDLE;
            nxt_q.sda_oe_n = 1'b1;
          end else if (q_ff.rw) begin
            nxt_q.st       = LCV_RD;
            nxt_q.tx       = reg_byte(q_ff);
            nxt_q.sda_oe_n = reg_byte(q_ff) >> 7 != 8'h0;
            if (q_ff.ptr == REG_BB_LO) begin
              nxt_q.bb_hi = q_ff.bb_res[15:8];
            end
            if (q_ff.ptr == REG_IR_LO) begin
              nxt_q.ir_hi = q_ff.ir_res[15:8];
            end
          end else begin
            nxt_q.st       = LCV_WR;
            nxt_q.sda_oe_n = 1'b1;
          end
        end
      end
      LCV_WR: begin
        if (scl_rise) begin
          nxt_q.sh      = {q_ff.sh[6:0], q_ff.sda_s};
          nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
        end else if (scl_fall && q_ff.bit_cnt == 4'h8) begin
          nxt_q.st       = LCV_ACK_W;
          nxt_q.sda_oe_n = 1'b0;
          if (q_ff.sh[CMD_BIT]) begin
            nxt_q.ptr = q_ff.sh[3:0];
          end else if (q_ff.ptr == REG_TIMING) begin
            nxt_q.timing = q_ff.sh;
          end
        end
      end
      LCV_ACK_W: begin
        if (scl_fall) begin
          nxt_q.st       = LCV_WR;
          nxt_q.bit_cnt  = 4'h0;
          nxt_q.sda_oe_n = 1'b1;
        end
      end
      LCV_RD: begin
        if (scl_fall) begin
          nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
          if (q_ff.bit_cnt == 4'h7) begin
            nxt_q.st       = LCV_ACK_R;
            nxt_q.sda_oe_n = 1'b1;
          end else begin
            nxt_q.tx       = {q_ff.tx[6:0], 1'b0};
            nxt_q.sda_oe_n = q_ff.tx[6];
          end
        end
      end
      default: begin
        nxt_q.st       = LCV_IDLE;
        nxt_q.sda_oe_n = 1'b1;
      end
    endcase

    if (bus_start) begin
      nxt_q.st       = LCV_ADDR;
      nxt_q.bit_cnt  = 4'h0;
      nxt_q.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      nxt_q.st       = LCV_IDLE;
      nxt_q.sda_oe_n = 1'b1;
    end
    // A stuck-low line abandons any transfer and frees the data line.
    if (q_ff.tout_cnt == 24'(TOUT_CYC_P - 1)) begin
      nxt_q.st       = LCV_IDLE;
      nxt_q.sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q_ff          <= '0;
      q_ff.scl_m    <= 1'b1;
      q_ff.scl_s    <= 1'b1;
      q_ff.scl_p    <= 1'b1;
      q_ff.sda_m    <= 1'b1;
      q_ff.sda_s    <= 1'b1;
      q_ff.sda_p    <= 1'b1;
      q_ff.own_addr <= ADDR_FLOAT;
      q_ff.timing   <= TIMING_RST;
      q_ff.cur_tim  <= TIMING_RST;
      q_ff.st       <= LCV_IDLE;
      q_ff.sda_oe_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sda_out  = q_ff.sda_out;
  assign sda_oe_n = q_ff.sda_oe_n;

endmodule : lcv_top

// >>> tb/lcv_top_assertions.sv
/*
  Pin-level checks on the serial slave of the light conversion block.
  Assumes a bind onto lcv_top; sda_in is the pulled-up wire fed back.
*/
`timescale 1ns/1ps
module lcv_top_assertions
  import lcv_pkg::*;
#(
  parameter int TOUT_CYC_P = TOUT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  // Counts cycles with either wire low, as the bus timeout does.
  logic [23:0] low_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (scl_in && sda_in)) begin
      low_ff <= 24'h0;
    end else if (low_ff != 24'hffffff) begin
      low_ff <= low_ff + 24'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_DRV_ZERO: assert property (sda_out == 1'b0)
    else $error("sda drive value is not zero");
  AST_RST_FREE: assert property ($rose(rst_n) |-> sda_oe_n)
    else $error("sda pulled at reset release");
  AST_PULL_SCL_LOW: assert property ($fell(sda_oe_n) |->
    !scl_in && !$past(scl_in) && !$past(scl_in, 2))
    else $error("sda pull started outside scl low");
  AST_FREE_SCL_LOW: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("sda release while scl high");
  AST_HOLD_SCL_HIGH: assert property ($rose(scl_in) |=> $stable(sda_oe_n)[*3])
    else $error("sda drive changed while scl high");
  AST_STOP_FREE: assert property (scl_in && $rose(sda_in) |=> sda_oe_n[*4])
    else $error("sda pulled right after stop");
  AST_TOUT: assert property (low_ff == 24'(TOUT_CYC_P + 12) |-> sda_oe_n)
    else $error("bus timeout did not release sda");
  AST_DRV_BOUND: assert property ($fell(sda_oe_n) |-> ##[1:300] sda_oe_n)
    else $error("sda held low too long");
endmodule : lcv_top_assertions

bind lcv_top lcv_top_assertions #(.TOUT_CYC_P(TOUT_CYC_P)) u_lcv_chk (
  .clk_sys  (clk_sys),
  .rst_n    (rst_n),
  .scl_in   (scl_in),
  .sda_in   (sda_in),
  .sda_out  (sda_out),
  .sda_oe_n (sda_oe_n)
);

// >>> tb/lcv_host.sv
/*
  Behavioural two-wire host: start, stop, bits and bytes, MSB first.
  Assumes an open-drain sda wire built by the bench with a pull-up.
*/
`timescale 1ns/1ps
module lcv_host (
  input  wire logic clk_sys,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv_n
);
  // Quarter of the scl period in clk_sys cycles: 2 gives a 160 ns clock,
  // which still leaves the slave's synchroniser four cycles per level.
  localparam int Q = 2;
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic wq(input int n);
    repeat (n * Q) @(negedge clk_sys);
  endtask : wq
  task automatic start();
    wq(1);
    sda_drv_n = 1'b1;
    wq(1);
    scl = 1'b1;
    wq(2);
    sda_drv_n = 1'b0;
    wq(2);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wq(1);
    sda_drv_n = 1'b0;
    wq(1);
    scl = 1'b1;
    wq(2);
    sda_drv_n = 1'b1;
    wq(2);
  endtask : stop
  task automatic xbit(input logic b, output logic r);
    wq(1);
    sda_drv_n = b;
    wq(1);
    scl = 1'b1;
    wq(1);
    r = sda_in;
    wq(1);
    scl = 1'b0;
  endtask : xbit
  task automatic bits(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
      q = {q[6:0], r};
    end
  endtask : bits
  task automatic xbyte(input logic [7:0] d, input logic ain, output logic [7:0] q,
                       output logic ack);
    bits(d, q);
    xbit(ain, ack);
  endtask : xbyte
  task automatic adr(input logic [6:0] a, input logic rw, output logic ack);
    logic [7:0] x;
    xbyte({a, rw}, 1'b1, x, ack);
  endtask : adr
endmodule : lcv_host

// >>> tb/lcv_top_test.sv
/*
  Self-checking bench for lcv_top: addresses, registers, conversions and
  bus timeout. Assumes lcv_host as the host and a pulled-up sda wire.
*/
`timescale 1ns/1ps
module lcv_top_test
  import lcv_pkg::*;
();
  localparam int TOUT = 200;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] addr_sel = STRAP_FLOAT;
  logic       bb_pulse = 1'b0;
  logic       ir_pulse = 1'b0;
  logic       bb_en = 1'b0;
  logic       ir_en = 1'b0;
  logic [1:0] pc = 2'h0;
  logic       scl, sda_drv_n, sda_out, sda_oe_n, sda_w;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cyc = 0;
  assign sda_w = (sda_oe_n && sda_drv_n) ? 1'b1 : 1'b0;
  lcv_top #(.OSC_DIV_P(2), .INTEG_UNIT_P(2), .TOUT_CYC_P(TOUT)) dut (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .scl_in   (scl),
    .sda_in   (sda_w),
    .addr_sel (addr_sel),
    .bb_pulse (bb_pulse),
    .ir_pulse (ir_pulse),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n)
  );
  lcv_host host (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda_drv_n(sda_drv_n));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // A pulse every third cycle outruns the two-tick limit, so a lit
  // channel at high gain always ends at full scale whatever the phase.
  always @(negedge clk_sys) begin
    pc <= (pc == 2'h2) ? 2'h0 : pc + 2'h1;
    bb_pulse <= bb_en && (pc == 2'h0);
    ir_pulse <= ir_en && (pc == 2'h0);
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset(input logic [1:0] s);
    @(negedge clk_sys);
    addr_sel = s;
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
  endtask : do_reset
  task automatic rd(input logic [3:0] r, input int n, output logic [7:0] q);
    logic a;
    logic [7:0] x;
    host.start();
    host.adr(ADDR_FLOAT, 1'b0, a);
    host.xbyte({4'h8, r}, 1'b1, x, a);
    host.start();
    host.adr(ADDR_FLOAT, 1'b1, a);
    for (int i = 0; i < n; i++) begin
      host.xbyte(8'hff, i == n - 1, q, a);
    end
    host.stop();
  endtask : rd
  task automatic rdw(input logic [3:0] r, output logic [15:0] v);
    rd(r, 1, v[7:0]);
    rd(r + 4'h1, 1, v[15:8]);
  endtask : rdw
  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    logic a;
    logic [7:0] x;
    host.start();
    host.adr(ADDR_FLOAT, 1'b0, a);
    host.xbyte({4'h8, r}, 1'b1, x, a);
    host.xbyte(d, 1'b1, x, a);
    host.stop();
  endtask : wr
  task automatic t_regs();
    logic [7:0] q;
    logic [7:0] x;
    logic a;
    rd(REG_TIMING, 1, q);
    chk("timing_reset", {8'h00, TIMING_RST}, {8'h00, q});
    rd(REG_ID, 2, q);
    chk("id_second_byte", {8'h00, ID_VALUE}, {8'h00, q});
    rd(4'h7, 1, q);
    chk("unmapped", 16'h0000, {8'h00, q});
    wr(REG_ID, 8'h33);
    rd(REG_ID, 1, q);
    chk("id_kept", {8'h00, ID_VALUE}, {8'h00, q});
    host.start();
    host.adr(ADDR_FLOAT, 1'b0, a);
    host.xbyte(8'h81, 1'b1, x, a);
    host.xbyte(8'h8a, 1'b1, x, a);
    host.start();
    host.adr(ADDR_FLOAT, 1'b1, a);
    host.xbyte(8'hff, 1'b1, q, a);
    host.stop();
    chk("second_pointer", {8'h00, ID_VALUE}, {8'h00, q});
    rd(REG_TIMING, 1, q);
    chk("timing_untouched", {8'h00, TIMING_RST}, {8'h00, q});
  endtask : t_regs
  task automatic t_addr();
    logic [6:0] adrs [4];
    logic [6:0] own;
    logic a;
    adrs = '{ADDR_GND, ADDR_FLOAT, ADDR_VDD, ADDR_ALERT};
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      own = (s == 0) ? ADDR_GND : (s == 1) ? ADDR_FLOAT : ADDR_VDD;
      for (int k = 0; k < 4; k++) begin
        host.start();
        host.adr(adrs[k], 1'b0, a);
        host.stop();
        chk("addr_ack", {15'h0, !(adrs[k] == own || k == 3)}, {15'h0, a});
      end
    end
    do_reset(STRAP_FLOAT);
  endtask : t_addr
  task automatic t_tout();
    logic [7:0] x;
    logic a;
    host.start();
    host.bits({ADDR_FLOAT, 1'b0}, x);
    repeat (4) @(negedge clk_sys);
    chk("ack_pull", 16'h0000, {15'h0, sda_w});
    repeat (TOUT + 24) @(negedge clk_sys);
    chk("timeout_release", 16'h0001, {15'h0, sda_oe_n});
    host.stop();
    host.start();
    host.adr(ADDR_FLOAT, 1'b0, a);
    host.stop();
    chk("timeout_recover", 16'h0000, {15'h0, a});
  endtask : t_tout
  task automatic t_conv();
    logic [15:0] fs [3];
    logic [15:0] v;
    fs = '{16'h0009, 16'h004f, 16'h0140};
    bb_en = 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(REG_TIMING, {6'h00, c[1:0]});
      repeat (2600) @(negedge clk_sys);
      rdw(REG_BB_LO, v);
      chk("bb_full_scale", fs[c], v);
      rdw(REG_IR_LO, v);
      chk("ir_dark", 16'h0000, v);
    end
    ir_en = 1'b1;
    wr(REG_TIMING, 8'h00);
    repeat (2600) @(negedge clk_sys);
    rdw(REG_BB_LO, v);
    chk("bb_both_lit", 16'h0009, v);
    rdw(REG_IR_LO, v);
    chk("ir_both_lit", 16'h0009, v);
    wr(REG_TIMING, 8'h11);
    repeat (2600) @(negedge clk_sys);
    rdw(REG_IR_LO, v);
    chk("low_gain_range", 16'h0001, {15'h0, v >= 16'h0004 && v <= 16'h0005});
    bb_en = 1'b0;
    ir_en = 1'b0;
  endtask : t_conv
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    do_reset(STRAP_FLOAT);
    t_regs();
    t_addr();
    t_tout();
    t_conv();
    tally_and_finish();
  end
endmodule : lcv_top_test
